// >>> debug_link_registers_test.sv
`timescale 1ns/100ps
`default_nettype none
module debug_link_registers_test;
    logic       clk, nrst, link_enable, err_valid, acc_request, acc_response;
    logic       key_row_set, key_prog_set, key_erase_set, prog_done, erase_done;
    logic       sys_in_reset, sys_in_sleep, sys_locked;
    logic [2:0] err_code, scan_state;
    logic       acc_wr, acc_rd, pi, rso, nao, cdo, ibd, scr, sbe, srr, lrst, toe;
    logic [3:0] acc_addr;
    logic [7:0] acc_wdata, acc_rdata, guard_cycles, d;
    logic [1:0] lcs;
    logic       lr_seen, to_seen, rwf;
    int         fail_count, num_checks;
    dlr_regs dlr_regs_inst (.clk(clk), .nrst(nrst), .acc_wr(acc_wr), .acc_rd(acc_rd),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
        .link_enable(link_enable), .err_valid(err_valid), .err_code(err_code),
        .acc_request(acc_request), .acc_response(acc_response), .key_row_set(key_row_set),
        .key_prog_set(key_prog_set), .key_erase_set(key_erase_set), .prog_done(prog_done),
        .erase_done(erase_done), .sys_in_reset(sys_in_reset), .sys_in_sleep(sys_in_sleep),
        .sys_prog_ready(1'b0), .sys_row_ready(1'b0), .sys_locked(sys_locked),
        .scan_state(scan_state), .parity_ignore(pi), .response_signature_off(rso),
        .negative_ack_off(nao), .contention_detect_off(cdo), .inter_byte_delay_en(ibd),
        .guard_cycles(guard_cycles), .link_clock_select(lcs), .system_clock_request(scr),
        .sys_bus_enable(sbe), .sys_reset_req(srr), .row_write_final(rwf),
        .link_reset(lrst), .timeout_error(toe));
    dlr_debugger dlr_debugger_inst (.clk(clk), .acc_wr(acc_wr), .acc_rd(acc_rd),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata));
    // ------------------------------------------------------------
    // clock, pulse monitors and helpers
    // ------------------------------------------------------------
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (lrst === 1'b1) lr_seen = 1'b1;
        if (toe === 1'b1) to_seen = 1'b1;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        dlr_debugger_inst.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic finish_test();
        if (fail_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("guard", 8'h80, guard_cycles);
        chk("lclk", 8'h03, {6'h0, lcs});
        dlr_debugger_inst.rd(dlr_pkg::ADDR_PHY_REVISION, d);
        chk("rev", {dlr_pkg::INTERFACE_REVISION, 4'h0}, d & 8'hf0);
        rdc(dlr_pkg::ADDR_PHY_CTRL_PRI, 8'h00);
        link_enable = 1'b1;
        cyc(3);
        chk("system_clock_request", 8'h01, {7'h0, scr});
        rdc(dlr_pkg::ADDR_SYS_ACCESS, 8'h01);
        sys_in_sleep = 1'b1;
        dlr_debugger_inst.wr(dlr_pkg::ADDR_SYS_ACCESS, 8'h00);
        cyc(3);
        chk("bus off", 8'h00, {7'h0, sbe});
        dlr_debugger_inst.wr(dlr_pkg::ADDR_SYS_ACCESS, 8'h01);
        cyc(3);
        chk("bus on", 8'h01, {7'h0, sbe});
        sys_in_sleep = 1'b0;
    endtask
    task automatic t_ctrl();
        for (int k = 0; k < 8; k++) begin
            dlr_debugger_inst.wr(dlr_pkg::ADDR_PHY_CTRL_PRI, 8'hb8 | 8'(k));
            cyc(3);
            chk("guard", (k == 7) ? 8'h00 : 8'h80 >> k, guard_cycles);
            chk("flags", 8'h07, {5'h0, ibd, pi, rso});
        end
        dlr_debugger_inst.wr(dlr_pkg::ADDR_PHY_CTRL_PRI, 8'h05);
        lr_seen = 1'b0;
        dlr_debugger_inst.wr(dlr_pkg::ADDR_SYS_RESET_REQ, dlr_pkg::RESET_REQUEST_CODE);
        cyc(3);
        chk("sysrst", 8'h01, {7'h0, srr});
        rdc(dlr_pkg::ADDR_SYS_RESET_REQ, 8'h01);
        rdc(dlr_pkg::ADDR_SYS_STATE, 8'h21);
        chk("kept", 8'h04, guard_cycles);
        chk("no lrst", 8'h00, {7'h0, lr_seen});
        dlr_debugger_inst.wr(dlr_pkg::ADDR_SYS_RESET_REQ, 8'h58);
        cyc(3);
        chk("sysrst", 8'h00, {7'h0, srr});
        rdc(dlr_pkg::ADDR_SYS_RESET_REQ, 8'h00);
        dlr_debugger_inst.rd(dlr_pkg::ADDR_SYS_STATE, d);
        rdc(dlr_pkg::ADDR_SYS_STATE, 8'h01);
        sys_in_reset = 1'b1;
        cyc(2);
        sys_in_reset = 1'b0;
        cyc(2);
        rdc(dlr_pkg::ADDR_SYS_STATE, 8'h21);
        rdc(dlr_pkg::ADDR_SYS_STATE, 8'h01);
        dlr_debugger_inst.wr(dlr_pkg::ADDR_PHY_CTRL_PRI, 8'h00);
    endtask
    task automatic t_status();
        logic [2:0] codes[4] = '{3'h1, 3'h2, 3'h4, 3'h7};
        logic [1:0] sel[4] = '{2'h1, 2'h2, 2'h0, 2'h3};
        logic [1:0] exp[4] = '{2'h1, 2'h2, 2'h2, 2'h3};
        for (int i = 0; i < 4; i++) begin
            err_code = codes[i];
            err_valid = 1'b1;
            cyc(1);
            err_valid = 1'b0;
            rdc(dlr_pkg::ADDR_PHY_ERROR_SIG, {5'h0, codes[i]});
            dlr_debugger_inst.wr(dlr_pkg::ADDR_LINK_CLK_CTRL, {6'h0, sel[i]});
            rdc(dlr_pkg::ADDR_LINK_CLK_CTRL, {6'h0, exp[i]});
            scan_state = (i == 0) ? 3'h0 : codes[i - 1];
            cyc(2);
            rdc(dlr_pkg::ADDR_MEM_SCAN, {5'h0, scan_state});
        end
        err_code = 3'h1;
        err_valid = 1'b1;
        cyc(1);
        err_code = 3'h7;
        cyc(1);
        err_valid = 1'b0;
        rdc(dlr_pkg::ADDR_PHY_ERROR_SIG, 8'h07);
        rdc(dlr_pkg::ADDR_PHY_ERROR_SIG, 8'h00);
        key_row_set = 1'b1;
        key_prog_set = 1'b1;
        key_erase_set = 1'b1;
        cyc(1);
        {key_row_set, key_prog_set, key_erase_set} = 3'h0;
        rdc(dlr_pkg::ADDR_KEY_FLAGS, 8'h38);
        prog_done = 1'b1;
        cyc(1);
        prog_done = 1'b0;
        rdc(dlr_pkg::ADDR_KEY_FLAGS, 8'h28);
        erase_done = 1'b1;
        cyc(1);
        erase_done = 1'b0;
        rdc(dlr_pkg::ADDR_KEY_FLAGS, 8'h20);
        dlr_debugger_inst.wr(dlr_pkg::ADDR_SYS_ACCESS, 8'h03);
        cyc(1);
        chk("final", 8'h01, {7'h0, rwf});
        dlr_debugger_inst.wr(dlr_pkg::ADDR_KEY_FLAGS, 8'h20);
        rdc(dlr_pkg::ADDR_KEY_FLAGS, 8'h00);
    endtask
    task automatic t_timeout();
        acc_request = 1'b1;
        cyc(100);
        acc_response = 1'b1;
        cyc(1);
        {acc_request, acc_response} = 2'h0;
        rdc(dlr_pkg::ADDR_PHY_ERROR_SIG, 8'h00);
        to_seen = 1'b0;
        acc_request = 1'b1;
        cyc(65530);
        chk("early", 8'h00, {7'h0, to_seen});
        cyc(15);
        acc_request = 1'b0;
        chk("timeout", 8'h01, {7'h0, to_seen});
        rdc(dlr_pkg::ADDR_PHY_ERROR_SIG, 8'h03);
    endtask
    task automatic t_disable();
        dlr_debugger_inst.wr(dlr_pkg::ADDR_PHY_CTRL_SEC, 8'h18);
        dlr_debugger_inst.wr(dlr_pkg::ADDR_PHY_CTRL_PRI, 8'h23);
        key_erase_set = 1'b1;
        cyc(3);
        key_erase_set = 1'b0;
        chk("offs", 8'h03, {6'h0, nao, cdo});
        lr_seen = 1'b0;
        dlr_debugger_inst.wr(dlr_pkg::ADDR_PHY_CTRL_SEC, 8'h04);
        cyc(3);
        chk("cleared", 8'h80, {pi, nao, cdo, scr, 4'h0} | guard_cycles);
        chk("lrst", 8'h01, {7'h0, lr_seen});
        rdc(dlr_pkg::ADDR_KEY_FLAGS, 8'h00);
        rdc(dlr_pkg::ADDR_PHY_CTRL_SEC, 8'h00);
    endtask
    // ------------------------------------------------------------
    // stimulus, reset and watchdog
    // ------------------------------------------------------------
    initial begin
        {clk, nrst, link_enable, err_valid, acc_request, acc_response} = 6'h0;
        {key_row_set, key_prog_set, key_erase_set, prog_done, erase_done} = 5'h0;
        {sys_in_reset, sys_in_sleep, err_code, scan_state} = 8'h0;
        sys_locked = 1'b1;
        {fail_count, num_checks, lr_seen, to_seen} = 0;
        cyc(3);
        nrst = 1'b1;
        t_reset();
        t_ctrl();
        t_status();
        t_timeout();
        t_disable();
        finish_test();
    end
    initial begin
        #(90000 * 20);
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire

// >>> dlr_debugger.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// debugger model on the link access port
// ------------------------------------------------------------
module dlr_debugger (
    input  wire logic       clk,
    output var  logic       acc_wr,
    output var  logic       acc_rd,
    output var  logic [3:0] acc_addr,
    output var  logic [7:0] acc_wdata,
    input  wire logic [7:0] acc_rdata
);
    // port idle at time zero
    initial begin
        acc_wr    = 1'b0;
        acc_rd    = 1'b0;
        acc_addr  = 4'h0;
        acc_wdata = 8'h00;
    end
    // one write strobe; released lines show the inverse value
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        acc_addr  = a;
        acc_wdata = d;
        acc_wr    = 1'b1;
        @(negedge clk);
        acc_wr    = 1'b0;
        acc_addr  = ~a;
        acc_wdata = ~d;
    endtask
    // one read strobe, data taken the cycle after
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk);
        acc_addr = a;
        acc_rd   = 1'b1;
        @(negedge clk);
        acc_rd   = 1'b0;
        acc_addr = ~a;
        d        = acc_rdata;
    endtask
endmodule
`default_nettype wire

// >>> dlr_pkg.sv
package dlr_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_PHY_REVISION   = 4'h0;
    localparam logic [3:0] ADDR_PHY_ERROR_SIG  = 4'h1;
    localparam logic [3:0] ADDR_PHY_CTRL_PRI   = 4'h2;
    localparam logic [3:0] ADDR_PHY_CTRL_SEC   = 4'h3;
    localparam logic [3:0] ADDR_KEY_FLAGS      = 4'h7;
    localparam logic [3:0] ADDR_SYS_RESET_REQ  = 4'h8;
    localparam logic [3:0] ADDR_LINK_CLK_CTRL  = 4'h9;
    localparam logic [3:0] ADDR_SYS_ACCESS     = 4'ha;
    localparam logic [3:0] ADDR_SYS_STATE      = 4'hb;
    localparam logic [3:0] ADDR_MEM_SCAN       = 4'hc;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_INTER_BYTE_DELAY = 7;
    localparam int POS_PARITY_IGNORE    = 5;
    localparam int POS_TIMEOUT_OFF      = 4;
    localparam int POS_RESP_SIG_OFF     = 3;
    localparam int POS_NEG_ACK_OFF      = 4;
    localparam int POS_CONTENTION_OFF   = 3;
    localparam int POS_IFACE_DISABLE    = 2;
    localparam int POS_USER_ROW_KEY     = 5;
    localparam int POS_MEM_PROG_KEY     = 4;
    localparam int POS_ERASE_KEY        = 3;
    localparam int POS_SYS_RESET_ACTIVE = 5;
    localparam int POS_IN_SLEEP         = 4;
    localparam int POS_PROG_READY       = 3;
    localparam int POS_ROW_READY        = 2;
    localparam int POS_LOCKED           = 0;
    localparam int POS_ROW_FINAL        = 1;
    localparam int POS_CLK_REQUEST      = 0;
    // ------------------------------------------------------------
    // codes and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] INTERFACE_REVISION = 4'h3; // arbitrary revision code
    localparam logic [7:0] RESET_REQUEST_CODE = 8'h59;
    localparam logic [7:0] CTRL_RESET         = 8'h00;
    localparam logic [1:0] LINK_CLK_DEFAULT   = 2'h3;
    localparam logic [1:0] LINK_CLK_16MHZ     = 2'h1;
    localparam logic [1:0] LINK_CLK_8MHZ      = 2'h2;
    localparam logic [1:0] LINK_CLK_RESERVED  = 2'h0;
    localparam logic [2:0] ERR_NONE           = 3'h0;
    localparam logic [2:0] ERR_PARITY         = 3'h1;
    localparam logic [2:0] ERR_FRAME          = 3'h2;
    localparam logic [2:0] ERR_TIMEOUT        = 3'h3;
    localparam logic [2:0] ERR_CLOCK_RECOVERY = 3'h4;
    localparam logic [2:0] ERR_CONTENTION     = 3'h7;
    localparam logic [2:0] GUARD_OFF          = 3'h7;
    localparam logic [7:0] GUARD_MAX_CYCLES   = 8'h80;
    localparam int         TIMEOUT_CYCLES     = 65536;
    localparam int         IDLE_CHARS_BETWEEN = 2;
    localparam logic [2:0] SCAN_OFF           = 3'h0;
    localparam logic [2:0] SCAN_BUSY          = 3'h1;
    localparam logic [2:0] SCAN_GOOD          = 3'h2;
    localparam logic [2:0] SCAN_FAIL          = 3'h4;
endpackage

// >>> dlr_regs.sv
`timescale 1ns/100ps
`default_nettype none
module dlr_regs (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       acc_wr,
    input  wire logic       acc_rd,
    input  wire logic [3:0] acc_addr,
    input  wire logic [7:0] acc_wdata,
    output logic      [7:0] acc_rdata,
    input  wire logic       link_enable,
    input  wire logic       err_valid,
    input  wire logic [2:0] err_code,
    input  wire logic       acc_request,
    input  wire logic       acc_response,
    input  wire logic       key_row_set,
    input  wire logic       key_prog_set,
    input  wire logic       key_erase_set,
    input  wire logic       prog_done,
    input  wire logic       erase_done,
    input  wire logic       sys_in_reset,
    input  wire logic       sys_in_sleep,
    input  wire logic       sys_prog_ready,
    input  wire logic       sys_row_ready,
    input  wire logic       sys_locked,
    input  wire logic [2:0] scan_state,
    output logic            parity_ignore,
    output logic            response_signature_off,
    output logic            negative_ack_off,
    output logic            contention_detect_off,
    output logic            inter_byte_delay_en,
    output logic      [7:0] guard_cycles,
    output logic      [1:0] link_clock_select,
    output logic            system_clock_request,
    output logic            sys_bus_enable,
    output logic            sys_reset_req,
    output logic            row_write_final,
    output logic            link_reset,
    output logic            timeout_error
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [2:0]  err_q;
    logic [7:0]  ctrl_pri_q;
    logic [4:2]  ctrl_sec_q;
    logic [5:3]  key_q;
    logic        rst_req_q;
    logic [1:0]  clk_sel_q;
    logic        clk_req_q;
    logic        row_final_q;
    logic        rst_seen_q;
    logic        en_q;
    logic [16:0] tmo_q;
    logic        tmo_flag_q;
    logic        link_rst_q;
    logic        wr_dis;
    logic        rd_err;
    logic        rd_state;
    logic        tmo_hit;

    assign wr_dis   = acc_wr && acc_addr == dlr_pkg::ADDR_PHY_CTRL_SEC
                      && acc_wdata[dlr_pkg::POS_IFACE_DISABLE];
    assign rd_err   = acc_rd && acc_addr == dlr_pkg::ADDR_PHY_ERROR_SIG;
    assign rd_state = acc_rd && acc_addr == dlr_pkg::ADDR_SYS_STATE;
    assign tmo_hit  = tmo_q == 17'(dlr_pkg::TIMEOUT_CYCLES - 1) && acc_request;

    // ------------------------------------------------------------
    // enable tracking and link reset
    // ------------------------------------------------------------
    // link reset pulses on disable; system reset never reaches here
    // en_q follows the link only, so a disable keeps clock request down
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en_q       <= 1'b0;
            link_rst_q <= 1'b0;
        end else begin
            en_q       <= link_enable;
            link_rst_q <= wr_dis;
        end
    end

    // ------------------------------------------------------------
    // error signature
    // ------------------------------------------------------------
    // newest error wins, also over a read in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            err_q <= dlr_pkg::ERR_NONE;
        end else if (wr_dis) begin
            err_q <= dlr_pkg::ERR_NONE;
        end else if (tmo_hit) begin
            err_q <= dlr_pkg::ERR_TIMEOUT;
        end else if (err_valid) begin
            err_q <= err_code;
        end else if (rd_err) begin
            err_q <= dlr_pkg::ERR_NONE;
        end
    end

    // ------------------------------------------------------------
    // access layer time-out counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tmo_q      <= '0;
            tmo_flag_q <= 1'b0;
        end else begin
            tmo_flag_q <= tmo_hit && !ctrl_pri_q[dlr_pkg::POS_TIMEOUT_OFF];
            if (!acc_request || acc_response || tmo_hit ||
                ctrl_pri_q[dlr_pkg::POS_TIMEOUT_OFF]) begin
                tmo_q <= '0;
            end else begin
                tmo_q <= tmo_q + 17'h00001;
            end
        end
    end

    // ------------------------------------------------------------
    // physical configuration
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_pri_q <= dlr_pkg::CTRL_RESET;
            ctrl_sec_q <= '0;
        end else if (wr_dis) begin
            ctrl_pri_q <= dlr_pkg::CTRL_RESET;
            ctrl_sec_q <= '0;
        end else if (acc_wr && acc_addr == dlr_pkg::ADDR_PHY_CTRL_PRI) begin
            ctrl_pri_q <= acc_wdata & 8'hbf;
        end else if (acc_wr && acc_addr == dlr_pkg::ADDR_PHY_CTRL_SEC) begin
            ctrl_sec_q <= {acc_wdata[4:3], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // key flags
    // ------------------------------------------------------------
    // done clears the prog and erase keys, a key flags write the row key; a new set in the same cycle still wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            key_q <= '0;
        end else if (wr_dis) begin
            key_q <= '0;
        end else begin
            if (key_row_set) begin
                key_q[dlr_pkg::POS_USER_ROW_KEY] <= 1'b1;
            end else if (acc_wr && acc_addr == dlr_pkg::ADDR_KEY_FLAGS
                         && acc_wdata[dlr_pkg::POS_USER_ROW_KEY]) begin
                key_q[dlr_pkg::POS_USER_ROW_KEY] <= 1'b0;
            end
            if (key_prog_set) begin
                key_q[dlr_pkg::POS_MEM_PROG_KEY] <= 1'b1;
            end else if (prog_done) begin
                key_q[dlr_pkg::POS_MEM_PROG_KEY] <= 1'b0;
            end
            if (key_erase_set) begin
                key_q[dlr_pkg::POS_ERASE_KEY] <= 1'b1;
            end else if (erase_done) begin
                key_q[dlr_pkg::POS_ERASE_KEY] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // access layer control
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_req_q   <= 1'b0;
            clk_sel_q   <= dlr_pkg::LINK_CLK_DEFAULT;
            clk_req_q   <= 1'b0;
            row_final_q <= 1'b0;
        end else if (wr_dis || !link_enable) begin
            rst_req_q   <= 1'b0;
            clk_sel_q   <= dlr_pkg::LINK_CLK_DEFAULT;
            clk_req_q   <= 1'b0;
            row_final_q <= 1'b0;
        end else begin
            if (!en_q) begin
                clk_req_q <= 1'b1;
            end
            if (acc_wr && acc_addr == dlr_pkg::ADDR_SYS_RESET_REQ) begin
                rst_req_q <= acc_wdata == dlr_pkg::RESET_REQUEST_CODE;
            end
            if (acc_wr && acc_addr == dlr_pkg::ADDR_LINK_CLK_CTRL
                && acc_wdata[1:0] != dlr_pkg::LINK_CLK_RESERVED) begin
                clk_sel_q <= acc_wdata[1:0];
            end
            if (acc_wr && acc_addr == dlr_pkg::ADDR_SYS_ACCESS) begin
                if (en_q) begin
                    clk_req_q <= acc_wdata[dlr_pkg::POS_CLK_REQUEST];
                end
                row_final_q <= acc_wdata[dlr_pkg::POS_ROW_FINAL]
                               && key_q[dlr_pkg::POS_USER_ROW_KEY];
            end else begin
                row_final_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // sticky system reset seen
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_seen_q <= 1'b0;
        end else if (sys_in_reset || rst_req_q) begin
            rst_seen_q <= 1'b1;
        end else if (rd_state) begin
            rst_seen_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read mux, only via the link access port
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            acc_rdata <= 8'h00;
        end else if (acc_rd) begin
            case (acc_addr)
                dlr_pkg::ADDR_PHY_REVISION:  acc_rdata <= {dlr_pkg::INTERFACE_REVISION, 4'h0};
                dlr_pkg::ADDR_PHY_ERROR_SIG: acc_rdata <= {5'h00, err_q};
                dlr_pkg::ADDR_PHY_CTRL_PRI:  acc_rdata <= ctrl_pri_q;
                dlr_pkg::ADDR_PHY_CTRL_SEC:  acc_rdata <= {3'h0, ctrl_sec_q, 2'h0};
                dlr_pkg::ADDR_KEY_FLAGS:     acc_rdata <= {2'h0, key_q, 3'h0};
                dlr_pkg::ADDR_SYS_RESET_REQ: acc_rdata <= {7'h00, rst_req_q};
                dlr_pkg::ADDR_LINK_CLK_CTRL: acc_rdata <= {6'h00, clk_sel_q};
                dlr_pkg::ADDR_SYS_ACCESS:    acc_rdata <= {7'h00, clk_req_q};
                dlr_pkg::ADDR_SYS_STATE:     acc_rdata <= {2'h0, rst_seen_q || sys_in_reset,
                                                 sys_in_sleep, sys_prog_ready,
                                                 sys_row_ready, 1'b0, sys_locked};
                dlr_pkg::ADDR_MEM_SCAN:      acc_rdata <= {5'h00, scan_state};
                default:                     acc_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            parity_ignore          <= 1'b0;
            response_signature_off <= 1'b0;
            negative_ack_off       <= 1'b0;
            contention_detect_off  <= 1'b0;
            inter_byte_delay_en    <= 1'b0;
            guard_cycles           <= dlr_pkg::GUARD_MAX_CYCLES;
            link_clock_select      <= dlr_pkg::LINK_CLK_DEFAULT;
            system_clock_request   <= 1'b0;
            sys_bus_enable         <= 1'b0;
            sys_reset_req          <= 1'b0;
            row_write_final        <= 1'b0;
            link_reset             <= 1'b0;
            timeout_error          <= 1'b0;
        end else begin
            parity_ignore          <= ctrl_pri_q[dlr_pkg::POS_PARITY_IGNORE];
            response_signature_off <= ctrl_pri_q[dlr_pkg::POS_RESP_SIG_OFF];
            negative_ack_off       <= ctrl_sec_q[dlr_pkg::POS_NEG_ACK_OFF];
            contention_detect_off  <= ctrl_sec_q[dlr_pkg::POS_CONTENTION_OFF];
            inter_byte_delay_en    <= ctrl_pri_q[dlr_pkg::POS_INTER_BYTE_DELAY];
            if (ctrl_pri_q[2:0] == dlr_pkg::GUARD_OFF) begin
                guard_cycles <= 8'h00;
            end else begin
                guard_cycles <= dlr_pkg::GUARD_MAX_CYCLES >> ctrl_pri_q[2:0];
            end
            link_clock_select      <= clk_sel_q;
            system_clock_request   <= clk_req_q;
            sys_bus_enable         <= clk_req_q || !sys_in_sleep;
            sys_reset_req          <= rst_req_q;
            row_write_final        <= row_final_q;
            link_reset             <= link_rst_q;
            timeout_error          <= tmo_flag_q;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence reset_code_write_s;
        acc_wr && acc_addr == dlr_pkg::ADDR_SYS_RESET_REQ
            && acc_wdata == dlr_pkg::RESET_REQUEST_CODE && link_enable && !wr_dis;
    endsequence

    reset_request_a: assert property (@(posedge clk) disable iff (!nrst)
        reset_code_write_s |-> ##2 sys_reset_req)
        else $error("reset request not raised");
    error_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        rd_err && !err_valid && !tmo_hit && !wr_dis |=> err_q == dlr_pkg::ERR_NONE)
        else $error("error field not cleared on read");
    error_load_a: assert property (@(posedge clk) disable iff (!nrst)
        err_valid && !tmo_hit && !wr_dis |=> err_q == $past(err_code))
        else $error("error field not loaded");
    disable_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_dis |=> key_q == 3'h0 && ctrl_pri_q == 8'h00 && !clk_req_q ##1 link_reset)
        else $error("disable did not clear state");
    guard_off_a: assert property (@(posedge clk) disable iff (!nrst)
        ctrl_pri_q[2:0] == 3'h7 |=> guard_cycles == 8'h00)
        else $error("guard time not off");
    reset_read_a: assert property (@(posedge clk) disable iff (!nrst)
        acc_rd && acc_addr == dlr_pkg::ADDR_SYS_RESET_REQ |=> acc_rdata[7:1] == 7'h00
            && acc_rdata[0] == $past(rst_req_q))
        else $error("reset request readback wrong");
    clock_request_a: assert property (@(posedge clk) disable iff (!nrst)
        link_enable && !en_q && !wr_dis |=> clk_req_q)
        else $error("clock request not set on enable");
    revision_read_a: assert property (@(posedge clk) disable iff (!nrst)
        acc_rd && acc_addr == dlr_pkg::ADDR_PHY_REVISION
            |=> acc_rdata == {dlr_pkg::INTERFACE_REVISION, 4'h0})
        else $error("revision read wrong");

    sequence reset_other_write_s;
        acc_wr && acc_addr == dlr_pkg::ADDR_SYS_RESET_REQ
            && acc_wdata != dlr_pkg::RESET_REQUEST_CODE && link_enable && !wr_dis;
    endsequence

    reset_release_a: assert property (@(posedge clk) disable iff (!nrst)
        reset_other_write_s |-> ##2 !sys_reset_req)
        else $error("reset request not released");
    timeout_flag_a: assert property (@(posedge clk) disable iff (!nrst)
        tmo_hit && !wr_dis && !ctrl_pri_q[dlr_pkg::POS_TIMEOUT_OFF]
            |=> err_q == dlr_pkg::ERR_TIMEOUT ##1 timeout_error)
        else $error("time-out not flagged");
    program_done_a: assert property (@(posedge clk) disable iff (!nrst)
        prog_done && !key_prog_set |=> !key_q[dlr_pkg::POS_MEM_PROG_KEY])
        else $error("programming key not cleared");
    erase_done_a: assert property (@(posedge clk) disable iff (!nrst)
        erase_done && !key_erase_set |=> !key_q[dlr_pkg::POS_ERASE_KEY])
        else $error("erase key not cleared");
    parity_follow_a: assert property (@(posedge clk) disable iff (!nrst)
        ctrl_pri_q[dlr_pkg::POS_PARITY_IGNORE] |=> parity_ignore)
        else $error("parity ignore not driven");
    nack_follow_a: assert property (@(posedge clk) disable iff (!nrst)
        ctrl_sec_q[dlr_pkg::POS_NEG_ACK_OFF] |=> negative_ack_off)
        else $error("negative ack off not driven");
    contention_follow_a: assert property (@(posedge clk) disable iff (!nrst)
        ctrl_sec_q[dlr_pkg::POS_CONTENTION_OFF] |=> contention_detect_off)
        else $error("contention off not driven");
    bus_enable_a: assert property (@(posedge clk) disable iff (!nrst)
        clk_req_q |=> sys_bus_enable)
        else $error("system bus not reachable");
    status_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        rd_state && !sys_in_reset && !rst_req_q |=> !rst_seen_q)
        else $error("reset active bit not cleared on read");
    scan_read_a: assert property (@(posedge clk) disable iff (!nrst)
        acc_rd && acc_addr == dlr_pkg::ADDR_MEM_SCAN
            |=> acc_rdata == {5'h00, $past(scan_state)})
        else $error("scan state read wrong");
endmodule
`default_nettype wire
